// ---- design/bfc_flow.sv ----
`timescale 1ns/1ps
// What this block does
// [RQ1] indirect jump loads PC from Z pointer, taking two cycles
// [RQ2] indirect call loads PC from Z pointer, taking three cycles
// [RQ3] compare-skip-equal skips next instruction on equal registers, flags untouched
// [RQ4] register bit-test skips on bit clear or set, flags untouched
// [RQ5] I/O bit-test skips on bit zero or one, flags untouched
// [RQ6] compare-immediate subtracts constant, updates Z N V C H in one cycle
// [RQ7] generic flag branches jump to PC+k+1 on selected bit set/clear
// [RQ8] signed ge/lt branches taken on N xor V zero/one
// [RQ9] same-or-higher branch taken when carry is zero
// [RQ10] half-carry branches taken on H one or zero
// [RQ11] transfer-flag branches taken on T one or zero
// [RQ12] overflow branches taken on V one or zero
// [RQ13] interrupt-state branches taken on I one or zero
// [RQ14] sign branches taken on N one or zero
// [RQ15] equality branches taken on Z one or zero
// [RQ16] carry branches taken on C one or zero, two cycles when taken
// [RQ17] offset is a signed word count added to incremented PC
// [RQ18] skip costs 1 untaken, 2 over one word, 3 over two
module bfc_flow import bfc_pkg::*; (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  output logic BUSY,
  output logic [15:0] PROG_COUNTER
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] z;
    logic [7:0] flags;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [7:0] io;
    logic [11:0] ofs;
    logic two_word;
    logic [4:0] op;
    bfc_phase_t phase;
    logic [1:0] cnt;
    logic [1:0] last_cyc;
    logic taken;
    logic [15:0] tgt;
    logic [7:0] flg_tgt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bfc_regs_t;

  bfc_regs_t q;
  bfc_regs_t d;

  logic [4:0] lop;
  logic [2:0] lsel;
  logic legal;
  logic is_rel;
  logic is_skip;
  logic take;
  logic [7:0] cmp_flags;
  logic setup;
  logic commit;
  logic launch;
  logic busy;
  logic [15:0] rel_tgt;
  logic [15:0] pc_inc;
  logic [31:0] wmask;

  assign busy = q.phase == ST_EXEC;
  assign lop = PWDATA[CTRL_OP_LSB +: 5];
  assign lsel = PWDATA[CTRL_SEL_LSB +: 3];
  assign setup = PSEL && !PENABLE;
  assign commit = PSEL && PENABLE && PWRITE && q.pready && !q.pslverr;
  assign launch = commit && PADDR == OFS_CTRL && PSTRB[0];
  assign pc_inc = q.pc + 16'h0001;
  // offset widened with its sign, counted in words
  assign rel_tgt = pc_inc + {{4{q.ofs[11]}}, q.ofs}; // RQ17

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  bfc_cond u_cond (
    .op(lop),
    .sel(lsel),
    .flags(q.flags),
    .rd(q.rd),
    .rr(q.rr),
    .io(q.io),
    .legal(legal),
    .is_rel(is_rel),
    .is_skip(is_skip),
    .take(take)
  );

  bfc_cmpi u_cmpi (
    .rd(q.rd),
    .k(q.rr),
    .flags_in(q.flags),
    .flags_out(cmp_flags)
  );

  generate
    for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{PSTRB[b]}};
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] cur;
    logic [31:0] nw;
    cur = 32'h0000_0000;
    nw = 32'h0000_0000;
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // answer prepared in setup so every output stays a flop
    if (setup) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      unique case (PADDR)
        OFS_CTRL: begin
          d.prdata = {27'h0000000, q.op};
          // a new operation is refused while one runs
          d.pslverr = PWRITE && (busy || !legal);
        end
        OFS_OPND: d.prdata = {8'h00, q.io, q.rr, q.rd};
        OFS_OFFS: d.prdata = {20'h00000, q.ofs};
        OFS_ZPTR: d.prdata = {16'h0000, q.z};
        OFS_PC: d.prdata = {16'h0000, q.pc};
        OFS_FLAGS: d.prdata = {24'h000000, q.flags};
        OFS_NEXT: d.prdata = {31'h00000000, q.two_word};
        OFS_STAT: begin
          d.prdata = {24'h000000, 2'h0, q.last_cyc, 2'h0, q.taken, busy};
          d.pslverr = PWRITE;
        end
        default: d.pslverr = 1'b1;
      endcase
      // operands stay frozen while an operation runs
      if (PWRITE && busy) begin
        d.pslverr = 1'b1;
      end
    end
    if (commit) begin
      unique case (PADDR)
        OFS_OPND: cur = {8'h00, q.io, q.rr, q.rd};
        OFS_OFFS: cur = {20'h00000, q.ofs};
        OFS_ZPTR: cur = {16'h0000, q.z};
        OFS_PC: cur = {16'h0000, q.pc};
        OFS_FLAGS: cur = {24'h000000, q.flags};
        OFS_NEXT: cur = {31'h00000000, q.two_word};
        default: cur = 32'h0000_0000;
      endcase
      nw = (cur & ~wmask) | (PWDATA & wmask);
      unique case (PADDR)
        OFS_OPND: begin
          d.rd = nw[OPND_RD_LSB +: 8];
          d.rr = nw[OPND_RR_LSB +: 8];
          d.io = nw[OPND_IO_LSB +: 8];
        end
        OFS_OFFS: d.ofs = nw[11:0];
        OFS_ZPTR: d.z = nw[15:0];
        OFS_PC: d.pc = nw[15:0];
        OFS_FLAGS: d.flags = nw[7:0];
        OFS_NEXT: d.two_word = nw[0];
        default: d.two_word = q.two_word;
      endcase
    end
    if (launch) begin
      d.op = lop;
      d.phase = ST_EXEC;
      d.taken = take;
      d.flg_tgt = q.flags;
      d.tgt = pc_inc;
      d.cnt = CYC_ONE;
      if (lop == OP_INDIRECT_JUMP) begin
        d.tgt = q.z; // RQ1
        d.cnt = CYC_JUMP; // RQ1
      end else if (lop == OP_INDIRECT_CALL) begin
        d.tgt = q.z; // RQ2
        d.cnt = CYC_CALL; // RQ2
      end else if (lop == OP_COMPARE_IMMEDIATE) begin
        d.flg_tgt = cmp_flags; // RQ6
      end else if (is_rel && take) begin
        d.tgt = rel_tgt; // RQ7
        d.cnt = (lop == OP_RELATIVE_CALL) ? CYC_CALL : CYC_TWO; // RQ16
      end else if (is_skip && take) begin
        d.tgt = q.two_word ? q.pc + 16'h0003 : q.pc + 16'h0002; // RQ18
        d.cnt = q.two_word ? CYC_THREE : CYC_TWO; // RQ18
      end
      d.last_cyc = d.cnt;
    end
    // pc and flags move only on the last cycle of the operation
    if (busy) begin
      d.cnt = q.cnt - 2'h1;
      if (q.cnt == CYC_ONE) begin
        d.pc = q.tgt;
        d.flags = q.flg_tgt; // RQ3
        d.phase = ST_IDLE;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= '{pc: RST_PC, z: RST_ZPTR, flags: RST_FLAGS, phase: ST_IDLE,
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign PREADY = q.pready;
  assign PRDATA = q.prdata;
  assign PSLVERR = q.pslverr;
  assign BUSY = busy;
  assign PROG_COUNTER = q.pc;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_ind_jump;
    launch && lop == OP_INDIRECT_JUMP |=>
      busy [*2] ##1 (!busy && q.pc == q.z);
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong"); // RQ1

  property p_ind_call;
    launch && lop == OP_INDIRECT_CALL |=>
      busy [*3] ##1 (!busy && q.pc == q.z);
  endproperty
  a_ind_call: assert property (p_ind_call) else $error("indirect call wrong"); // RQ2

  property p_cse;
    launch && lop == OP_COMPARE_SKIP_EQUAL && q.rd == q.rr && !q.two_word
      |=> busy [*2] ##1 (!busy && q.pc == $past(q.pc, 3) + 16'h0002
      && q.flags == $past(q.flags, 3));
  endproperty
  a_cse: assert property (p_cse) else $error("equal skip wrong"); // RQ3

  property p_regskip_none;
    launch && lop == OP_SKIP_REG_BIT_SET && !q.rr[lsel] |=>
      busy ##1 (!busy && q.pc == $past(q.pc, 2) + 16'h0001);
  endproperty
  a_regskip_none: assert property (p_regskip_none) else $error("bit skip wrong"); // RQ4

  property p_ioskip_two;
    launch && lop == OP_SKIP_IO_BIT_CLEAR && !q.io[lsel] && q.two_word
      |=> busy [*3] ##1 (!busy && q.pc == $past(q.pc, 4) + 16'h0003);
  endproperty
  a_ioskip_two: assert property (p_ioskip_two) else $error("io skip wrong"); // RQ5

  property p_cmpi;
    launch && lop == OP_COMPARE_IMMEDIATE |=> busy ##1 (!busy
      && q.flags[FLG_Z] == ($past(q.rd, 2) == $past(q.rr, 2))
      && q.rd == $past(q.rd, 2) && q.pc == $past(q.pc, 2) + 16'h0001);
  endproperty
  a_cmpi: assert property (p_cmpi) else $error("compare immediate wrong"); // RQ6

  property p_brflag;
    launch && lop == OP_BRANCH_FLAG_SET && q.flags[lsel] |=>
      busy [*2] ##1 (q.pc == $past(q.pc, 3) + 16'h0001
      + {{4{$past(q.ofs[11], 3)}}, $past(q.ofs, 3)});
  endproperty
  a_brflag: assert property (p_brflag) else $error("flag branch target wrong"); // RQ7

  property p_signed_ge;
    launch && lop == OP_BRANCH_SIGNED_GE && (q.flags[FLG_N] ^ q.flags[FLG_V])
      |=> busy ##1 (!busy && q.pc == $past(q.pc, 2) + 16'h0001);
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong"); // RQ8

  property p_same_higher;
    launch && lop == OP_BRANCH_SAME_HIGHER && !q.flags[FLG_C] |=>
      busy [*2] ##1 !busy;
  endproperty
  a_same_higher: assert property (p_same_higher) else $error("unsigned branch wrong"); // RQ9

  property p_flags_kept;
    busy && q.op != OP_COMPARE_IMMEDIATE |=> $stable(q.flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags moved"); // RQ4

  property p_hc_clear;
    launch && lop == OP_BRANCH_HALFCARRY_CLEAR && q.flags[FLG_H] |=>
      busy ##1 (!busy && q.pc == $past(q.pc, 2) + 16'h0001);
  endproperty
  a_hc_clear: assert property (p_hc_clear) else $error("half-carry branch wrong"); // RQ10

  property p_tf_set;
    launch && lop == OP_BRANCH_TRANSFER_SET && q.flags[FLG_T] |=>
      busy [*2] ##1 (!busy && q.pc == $past(q.pc, 3) + 16'h0001
      + {{4{$past(q.ofs[11], 3)}}, $past(q.ofs, 3)});
  endproperty
  a_tf_set: assert property (p_tf_set) else $error("transfer branch wrong"); // RQ11

  property p_ovf_clear;
    launch && lop == OP_BRANCH_OVERFLOW_CLEAR && q.flags[FLG_V] |=>
      busy ##1 (!busy && q.pc == $past(q.pc, 2) + 16'h0001);
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow branch wrong"); // RQ12

  property p_irq_off;
    launch && lop == OP_BRANCH_IRQ_DISABLED && !q.flags[FLG_I] |=>
      busy [*2] ##1 !busy;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt branch wrong"); // RQ13

  property p_plus;
    launch && lop == OP_BRANCH_PLUS && q.flags[FLG_N] |=>
      busy ##1 (!busy && q.pc == $past(q.pc, 2) + 16'h0001);
  endproperty
  a_plus: assert property (p_plus) else $error("sign branch wrong"); // RQ14

  property p_not_equal;
    launch && lop == OP_BRANCH_NOT_EQUAL && !q.flags[FLG_Z] |=>
      busy [*2] ##1 (!busy && q.pc == $past(q.pc, 3) + 16'h0001
      + {{4{$past(q.ofs[11], 3)}}, $past(q.ofs, 3)});
  endproperty
  a_not_equal: assert property (p_not_equal) else $error("equality branch wrong"); // RQ15

  property p_carry_set;
    launch && lop == OP_BRANCH_CARRY_SET && q.flags[FLG_C] |=>
      busy [*2] ##1 !busy;
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry branch wrong"); // RQ16

  property p_rel_back;
    launch && lop == OP_RELATIVE_JUMP && q.ofs[11] |=>
      busy [*2] ##1 (!busy
      && q.pc == $past(q.pc, 3) + 16'h0001 + {4'hf, $past(q.ofs, 3)});
  endproperty
  a_rel_back: assert property (p_rel_back) else $error("backward jump wrong"); // RQ17

  property p_regskip_one;
    launch && lop == OP_SKIP_REG_BIT_CLEAR && !q.rr[lsel] && !q.two_word |=>
      busy [*2] ##1 (!busy && q.pc == $past(q.pc, 3) + 16'h0002);
  endproperty
  a_regskip_one: assert property (p_regskip_one) else $error("bit clear skip wrong"); // RQ18

  c_ind_jump: cover property (launch && lop == OP_INDIRECT_JUMP ##3 !busy);
  c_skip3: cover property (launch && is_skip && take && q.two_word);
  c_branch: cover property (launch && is_rel && take && q.ofs[11]);
  c_cmpi: cover property (launch && lop == OP_COMPARE_IMMEDIATE);
endmodule : bfc_flow

// ---- design/bfc_pkg.sv ----
package bfc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_OFFS = 8'h08;
  localparam logic [7:0] OFS_ZPTR = 8'h0c;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_NEXT = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SEL_LSB = 5;
  localparam int OPND_RD_LSB = 0;
  localparam int OPND_RR_LSB = 8;
  localparam int OPND_IO_LSB = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_CYC_LSB = 4;
  // ----------------------------------------
  // status flag positions
  // ----------------------------------------
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_ZPTR = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  localparam logic [4:0] OP_INDIRECT_JUMP = 5'h00;
  localparam logic [4:0] OP_INDIRECT_CALL = 5'h01;
  localparam logic [4:0] OP_RELATIVE_JUMP = 5'h02;
  localparam logic [4:0] OP_RELATIVE_CALL = 5'h03;
  localparam logic [4:0] OP_COMPARE_SKIP_EQUAL = 5'h04;
  localparam logic [4:0] OP_SKIP_REG_BIT_CLEAR = 5'h05;
  localparam logic [4:0] OP_SKIP_REG_BIT_SET = 5'h06;
  localparam logic [4:0] OP_SKIP_IO_BIT_CLEAR = 5'h07;
  localparam logic [4:0] OP_SKIP_IO_BIT_SET = 5'h08;
  localparam logic [4:0] OP_COMPARE_IMMEDIATE = 5'h09;
  localparam logic [4:0] OP_BRANCH_FLAG_SET = 5'h0a;
  localparam logic [4:0] OP_BRANCH_FLAG_CLEAR = 5'h0b;
  localparam logic [4:0] OP_BRANCH_SIGNED_GE = 5'h0c;
  localparam logic [4:0] OP_BRANCH_SIGNED_LT = 5'h0d;
  localparam logic [4:0] OP_BRANCH_SAME_HIGHER = 5'h0e;
  localparam logic [4:0] OP_BRANCH_HALFCARRY_SET = 5'h0f;
  localparam logic [4:0] OP_BRANCH_HALFCARRY_CLEAR = 5'h10;
  localparam logic [4:0] OP_BRANCH_TRANSFER_SET = 5'h11;
  localparam logic [4:0] OP_BRANCH_TRANSFER_CLEAR = 5'h12;
  localparam logic [4:0] OP_BRANCH_OVERFLOW_SET = 5'h13;
  localparam logic [4:0] OP_BRANCH_OVERFLOW_CLEAR = 5'h14;
  localparam logic [4:0] OP_BRANCH_IRQ_ENABLED = 5'h15;
  localparam logic [4:0] OP_BRANCH_IRQ_DISABLED = 5'h16;
  localparam logic [4:0] OP_BRANCH_MINUS = 5'h17;
  localparam logic [4:0] OP_BRANCH_PLUS = 5'h18;
  localparam logic [4:0] OP_BRANCH_EQUAL = 5'h19;
  localparam logic [4:0] OP_BRANCH_NOT_EQUAL = 5'h1a;
  localparam logic [4:0] OP_BRANCH_CARRY_SET = 5'h1b;
  localparam logic [4:0] OP_BRANCH_CARRY_CLEAR = 5'h1c;
  // ----------------------------------------
  // cycle counts
  // ----------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [1:0] CYC_JUMP = 2'h2;
  localparam logic [1:0] CYC_CALL = 2'h3;
  typedef enum logic {ST_IDLE, ST_EXEC} bfc_phase_t;
endpackage : bfc_pkg

// ---- design/bfc_cond.sv ----
`timescale 1ns/1ps
module bfc_cond import bfc_pkg::*; (
  input wire logic [4:0] op,
  input wire logic [2:0] sel,
  input wire logic [7:0] flags,
  input wire logic [7:0] rd,
  input wire logic [7:0] rr,
  input wire logic [7:0] io,
  output logic legal,
  output logic is_rel,
  output logic is_skip,
  output logic take
);
  always_comb begin
    legal = 1'b1;
    is_rel = 1'b1;
    is_skip = 1'b0;
    take = 1'b0;
    case (op)
      OP_INDIRECT_JUMP, OP_INDIRECT_CALL, OP_COMPARE_IMMEDIATE: begin
        is_rel = 1'b0;
        take = op != OP_COMPARE_IMMEDIATE;
      end
      OP_RELATIVE_JUMP, OP_RELATIVE_CALL: take = 1'b1;
      OP_COMPARE_SKIP_EQUAL: begin
        is_rel = 1'b0;
        is_skip = 1'b1;
        take = rd == rr; // RQ3
      end
      OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET: begin
        is_rel = 1'b0;
        is_skip = 1'b1;
        take = rr[sel] == (op == OP_SKIP_REG_BIT_SET); // RQ4
      end
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
        is_rel = 1'b0;
        is_skip = 1'b1;
        take = io[sel] == (op == OP_SKIP_IO_BIT_SET); // RQ5
      end
      OP_BRANCH_FLAG_SET: take = flags[sel]; // RQ7
      OP_BRANCH_FLAG_CLEAR: take = !flags[sel]; // RQ7
      OP_BRANCH_SIGNED_GE: take = !(flags[FLG_N] ^ flags[FLG_V]); // RQ8
      OP_BRANCH_SIGNED_LT: take = flags[FLG_N] ^ flags[FLG_V]; // RQ8
      OP_BRANCH_SAME_HIGHER: take = !flags[FLG_C]; // RQ9
      OP_BRANCH_HALFCARRY_SET: take = flags[FLG_H]; // RQ10
      OP_BRANCH_HALFCARRY_CLEAR: take = !flags[FLG_H]; // RQ10
      OP_BRANCH_TRANSFER_SET: take = flags[FLG_T]; // RQ11
      OP_BRANCH_TRANSFER_CLEAR: take = !flags[FLG_T]; // RQ11
      OP_BRANCH_OVERFLOW_SET: take = flags[FLG_V]; // RQ12
      OP_BRANCH_OVERFLOW_CLEAR: take = !flags[FLG_V]; // RQ12
      OP_BRANCH_IRQ_ENABLED: take = flags[FLG_I]; // RQ13
      OP_BRANCH_IRQ_DISABLED: take = !flags[FLG_I]; // RQ13
      OP_BRANCH_MINUS: take = flags[FLG_N]; // RQ14
      OP_BRANCH_PLUS: take = !flags[FLG_N]; // RQ14
      OP_BRANCH_EQUAL: take = flags[FLG_Z]; // RQ15
      OP_BRANCH_NOT_EQUAL: take = !flags[FLG_Z]; // RQ15
      OP_BRANCH_CARRY_SET: take = flags[FLG_C]; // RQ16
      OP_BRANCH_CARRY_CLEAR: take = !flags[FLG_C]; // RQ16
      default: begin
        legal = 1'b0;
        is_rel = 1'b0;
      end
    endcase
  end
endmodule : bfc_cond

// ---- design/bfc_cmpi.sv ----
`timescale 1ns/1ps
module bfc_cmpi import bfc_pkg::*; (
  input wire logic [7:0] rd,
  input wire logic [7:0] k,
  input wire logic [7:0] flags_in,
  output logic [7:0] flags_out
);
  logic [7:0] res;
  // result is only looked at, never written back
  always_comb begin
    res = rd - k; // RQ6
    flags_out = flags_in;
    flags_out[FLG_Z] = res == 8'h00; // RQ6
    flags_out[FLG_N] = res[7]; // RQ6
    flags_out[FLG_V] = (rd[7] & !k[7] & !res[7]) | (!rd[7] & k[7] & res[7]);
    flags_out[FLG_C] = (!rd[7] & k[7]) | (k[7] & res[7]) | (res[7] & !rd[7]);
    flags_out[FLG_H] = (!rd[3] & k[3]) | (k[3] & res[3]) | (res[3] & !rd[3]);
  end
endmodule : bfc_cmpi

// ---- bench/bfc_flow_tb.sv ----
`timescale 1ns/1ps
module bfc_flow_tb import bfc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, busy;
  logic [31:0] prdata;
  logic [15:0] pc_out;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] lfsr = 32'h1cba5557;

  bfc_flow uut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .BUSY(busy), .PROG_COUNTER(pc_out));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'h80200003 : 32'h0);
    return lfsr;
  endfunction : rnd

  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic err;
    apb(1'b1, a, d, r, err);
    chk({31'h0, err}, {31'h0, e}, "write error");
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                     input logic e);
    logic [31:0] r;
    logic err;
    apb(1'b0, a, 32'h0, r, err);
    chk({31'h0, err}, {31'h0, e}, "read error");
    chk(r & m, exp, "read data");
  endtask : rdc

  // counts busy cycles; returns when busy has dropped
  task automatic wait_busy(output int n);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 10) begin
      n++;
      @(negedge clk);
    end
  endtask : wait_busy

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  task automatic model(input logic [4:0] op, input logic [2:0] s, input logic [7:0] f,
      input logic [7:0] rd, input logic [7:0] rr, input logic [7:0] io, input logic tw,
      input logic [15:0] pc, input logic [15:0] z, input logic [11:0] k,
      output logic [15:0] npc, output logic [7:0] nf, output int cyc, output logic tk);
    logic [15:0] rel;
    logic [7:0] res;
    rel = pc + 16'h1 + {{4{k[11]}}, k};
    nf = f;
    tk = 1'b0;
    case (op)
      5'h04: tk = (rd == rr);
      5'h05: tk = !rr[s];
      5'h06: tk = rr[s];
      5'h07: tk = !io[s];
      5'h08: tk = io[s];
      5'h0a: tk = f[s];
      5'h0b: tk = !f[s];
      5'h0c: tk = !(f[2] ^ f[3]);
      5'h0d: tk = f[2] ^ f[3];
      5'h0e: tk = !f[0];
      5'h0f: tk = f[5];
      5'h10: tk = !f[5];
      5'h11: tk = f[6];
      5'h12: tk = !f[6];
      5'h13: tk = f[3];
      5'h14: tk = !f[3];
      5'h15: tk = f[7];
      5'h16: tk = !f[7];
      5'h17: tk = f[2];
      5'h18: tk = !f[2];
      5'h19: tk = f[1];
      5'h1a: tk = !f[1];
      5'h1b: tk = f[0];
      5'h1c: tk = !f[0];
      default: tk = 1'b0;
    endcase
    npc = pc + 16'h1;
    cyc = 1;
    if (op <= 5'h01) begin
      npc = z;
      cyc = (op == 5'h00) ? 2 : 3;
    end else if (op <= 5'h03) begin
      npc = rel;
      cyc = (op == 5'h02) ? 2 : 3;
    end else if (op <= 5'h08) begin
      if (tk) npc = pc + (tw ? 16'h3 : 16'h2);
      if (tk) cyc = tw ? 3 : 2;
    end else if (op == 5'h09) begin
      res = rd - rr;
      nf[1] = (res == 8'h0);
      nf[2] = res[7];
      nf[3] = (rd[7] & !rr[7] & !res[7]) | (!rd[7] & rr[7] & res[7]);
      nf[0] = (!rd[7] & rr[7]) | (rr[7] & res[7]) | (res[7] & !rd[7]);
      nf[5] = (!rd[3] & rr[3]) | (rr[3] & res[3]) | (res[3] & !rd[3]);
    end else if (tk) begin
      npc = rel;
      cyc = 2;
    end
  endtask : model

  task automatic run(input logic [4:0] op, input logic [1:0] rep);
    logic [31:0] w1, w2, w3;
    logic [15:0] npc;
    logic [7:0] nf, rr;
    logic tk;
    int cyc, n;
    w1 = rnd();
    w2 = rnd();
    w3 = rnd();
    // two-word follower and equal operands forced by rep bits 0 and 1, not left to luck
    w3[12] = rep[0];
    w3[20] = rep[1];
    rr = (op == 5'h04 && w3[20]) ? w2[15:8] : w2[7:0];
    wr(OFS_PC, {16'h0, w1[15:0]}, 1'b0);
    wr(OFS_ZPTR, {16'h0, w1[31:16]}, 1'b0);
    wr(OFS_FLAGS, {24'h0, w2[31:24]}, 1'b0);
    wr(OFS_OPND, {8'h0, w2[23:16], rr, w2[15:8]}, 1'b0);
    wr(OFS_OFFS, {20'h0, w3[11:0]}, 1'b0);
    wr(OFS_NEXT, {31'h0, w3[12]}, 1'b0);
    model(op, w3[15:13], w2[31:24], w2[15:8], rr, w2[23:16], w3[12], w1[15:0],
          w1[31:16], w3[11:0], npc, nf, cyc, tk);
    wr(OFS_CTRL, {24'h0, w3[15:13], op}, 1'b0);
    wait_busy(n);
    chk(n, cyc, "busy cycles");
    chk({16'h0, pc_out}, {16'h0, npc}, "program counter");
    rdc(OFS_FLAGS, 32'hff, {24'h0, nf}, 1'b0);
    rdc(OFS_PC, 32'hffff, {16'h0, npc}, 1'b0);
    if (op >= 5'h04 && op != 5'h09) rdc(OFS_STAT, 32'h33, {26'h0, cyc[1:0], 2'h0, tk, 1'b0}, 1'b0);
  endtask : run

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic err;
    int n;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({15'h0, busy, pc_out}, 32'h0, "reset outputs");
    rdc(OFS_FLAGS, 32'hff, 32'h0, 1'b0);
    rdc(OFS_ZPTR, 32'hffff, 32'h0, 1'b0);
    for (int rep = 0; rep < 8; rep++) begin
      for (int o = 0; o <= 28; o++) run(o[4:0], rep[1:0]);
    end
    for (int o = 29; o <= 31; o++) wr(OFS_CTRL, o, 1'b1);
    wr(OFS_STAT, 32'h3, 1'b1);
    rdc(8'h20, 32'hffffffff, 32'h0, 1'b1);
    // a control write without its low lane must not launch
    pstrb <= 4'he;
    apb(1'b1, OFS_CTRL, 32'h0, r, err);
    pstrb <= 4'hf;
    @(negedge clk);
    chk({31'h0, busy}, 32'h0, "no launch");
    wr(OFS_ZPTR, 32'h1234, 1'b0);
    wr(OFS_CTRL, {27'h0, OP_INDIRECT_CALL}, 1'b0);
    wr(OFS_PC, 32'h0055, 1'b1);
    wait_busy(n);
    chk({16'h0, pc_out}, 32'h1234, "call under refused write");
    wr(OFS_CTRL, {27'h0, OP_INDIRECT_CALL}, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({15'h0, busy, pc_out}, 32'h0, "second reset");
    rdc(OFS_ZPTR, 32'hffff, 32'h0, 1'b0);
    end_sim;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("BAD t=%0t timeout", $time);
      end_sim;
    end
  end
endmodule : bfc_flow_tb
